// >>> buck_regs_pkg.sv
/*
 * Constants and carrier types for the converter status, mask and configuration
 * register slice.
 * Assumes a 100 MHz system clock and a serial engine that turns bus
 * transactions into single-cycle register strobes.
 */
package buck_regs_pkg;

    // Register offsets
    localparam logic [7:0] CAUSE_FIRST_ADDR = 8'h01;
    localparam logic [7:0] CAUSE_SECOND_ADDR = 8'h02;
    localparam logic [7:0] STATUS_FLAGS_ADDR = 8'h03;
    localparam logic [7:0] RESERVED_SLOT_ADDR = 8'h04;
    localparam logic [7:0] ACTION_TRIGGER_ADDR = 8'h05;
    localparam logic [7:0] IRQ_MASK_FIRST_ADDR = 8'h06;
    localparam logic [7:0] IRQ_MASK_SECOND_ADDR = 8'h07;
    localparam logic [7:0] CONFIG_FIRST_ADDR = 8'h08;

    // Command bit positions
    localparam int APPLY_REF_BIT = 1;
    localparam int MAIN_ENABLE_BIT = 0;

    // Configuration field positions
    localparam int POWER_GOOD_DELAY_SEL_LSB = 6;
    localparam int MASK_ALL_BIT = 5;
    localparam int BIAS_DELAY_LSB = 3;

    // Implemented bits of the cause and mask registers
    localparam logic [7:0] CAUSE_FIRST_USED = 8'hBD;
    localparam logic [7:0] CAUSE_SECOND_USED = 8'h7F;

    // Reset values
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [1:0] POWER_GOOD_DELAY_SEL_RESET = 2'h0;
    localparam logic MASK_ALL_RESET = 1'b1;
    localparam logic [1:0] BIAS_DELAY_RESET = 2'h1;

    // Timing, delays in microseconds
    localparam int CLK_PERIOD_NS = 10;
    localparam int PG_DLY1_US = 250;
    localparam int PG_DLY2_US = 1000;
    localparam int PG_DLY3_US = 4000;
    localparam int BIAS_DLY0_US = 1000;
    localparam int BIAS_DLY1_US = 1250;
    localparam int BIAS_DLY2_US = 1500;
    localparam int BIAS_DLY3_US = 3000;
    localparam int DLY_CNT_W = 20;

    // Register strobe from the serial engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Conditions reported by the analog blocks
    typedef struct packed {
        logic sync_too_fast_flag;
        logic sync_too_slow_flag;
        logic bias_full_duty;
        logic main_const_current;
        logic main_full_duty;
        logic main_power_good;
        logic bias_power_good;
        logic [7:0] cause_first;
        logic [7:0] cause_second;
    } analog_in_s;

endpackage

// >>> buck_status_mask_config_regs.sv
/*
 * Status, command, interrupt mask and configuration registers of the step-down
 * controller, with the cause latches, interrupt output and good-pin delays.
 * Assumes the serial engine issues one-cycle read and write strobes on
 * sys_clk_i and samples read data on the cycle after a read strobe. Analog
 * condition inputs are asynchronous.
 */
// Overview of operation
// - Bits 7,6 flag sync clock too fast/slow
// - Bit 5 shows bias converter full duty
// - Bit 4 shows constant-current regulation
// - Bit 3 shows main converter full duty
// - Bit 2 shows power good; 1:0 zero
// - Reserved slot reads zero, ignores writes
// - Command writes trigger actions, not stored
// - Command bit 1 applies reference code
// - Command bit 0 starts main enable
// - Mask bits block matching cause bits
// - Mask-all forces every mask bit high
// - Mask-all resets to one
// - First mask covers bits 7,5,4,3,2,0
// - Second mask covers bits 6 to 0
// - Power-good delay 0, 0.25, 1, 4 ms
// - Bias-good delay 1, 1.25, 1.5, 3 ms
// - Cause bits clear on read once resolved
`timescale 1ns/10ps
module buck_status_mask_config_regs #(
    parameter int unsigned PG_DLY1_CYC = buck_regs_pkg::PG_DLY1_US * 1000
        / buck_regs_pkg::CLK_PERIOD_NS,
    parameter int unsigned PG_DLY2_CYC = buck_regs_pkg::PG_DLY2_US * 1000
        / buck_regs_pkg::CLK_PERIOD_NS,
    parameter int unsigned PG_DLY3_CYC = buck_regs_pkg::PG_DLY3_US * 1000
        / buck_regs_pkg::CLK_PERIOD_NS,
    parameter int unsigned BIAS_DLY0_CYC = buck_regs_pkg::BIAS_DLY0_US * 1000
        / buck_regs_pkg::CLK_PERIOD_NS,
    parameter int unsigned BIAS_DLY1_CYC = buck_regs_pkg::BIAS_DLY1_US * 1000
        / buck_regs_pkg::CLK_PERIOD_NS,
    parameter int unsigned BIAS_DLY2_CYC = buck_regs_pkg::BIAS_DLY2_US * 1000
        / buck_regs_pkg::CLK_PERIOD_NS,
    parameter int unsigned BIAS_DLY3_CYC = buck_regs_pkg::BIAS_DLY3_US * 1000
        / buck_regs_pkg::CLK_PERIOD_NS
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire buck_regs_pkg::reg_req_s req_i,
    input wire buck_regs_pkg::analog_in_s analog_i,
    output logic [7:0] rd_data_o,
    output logic irq_o,
    output logic apply_reference_cmd_o,
    output logic main_enable_start_o,
    output logic power_good_pin_o,
    output logic bias_good_pin_o
);

    typedef struct packed {
        buck_regs_pkg::analog_in_s sync1;
        buck_regs_pkg::analog_in_s sync2;
        buck_regs_pkg::analog_in_s sync3;
        buck_regs_pkg::analog_in_s stable;
        logic [7:0] mask_first;
        logic [7:0] mask_second;
        logic [1:0] pg_sel;
        logic mask_all;
        logic [1:0] bias_sel;
        logic [7:0] cause_first;
        logic [7:0] cause_second;
        logic [7:0] rdata;
        logic apply_pulse;
        logic enable_pulse;
        logic [buck_regs_pkg::DLY_CNT_W-1:0] pg_cnt;
        logic [buck_regs_pkg::DLY_CNT_W-1:0] bias_cnt;
        logic pg_pin;
        logic bias_pin;
    } state_s;

    localparam int CW = buck_regs_pkg::DLY_CNT_W;

    state_s state_reg;
    state_s state_next;
    logic [7:0] eff_mask_first;
    logic [7:0] eff_mask_second;
    logic [CW-1:0] pg_target;
    logic [CW-1:0] bias_target;
    logic [7:0] status_value;
    logic cfg_wr;

    assign eff_mask_first = state_reg.mask_all ? 8'hFF : state_reg.mask_first;
    assign eff_mask_second = state_reg.mask_all ? 8'hFF : state_reg.mask_second;

    assign irq_o = |(state_reg.cause_first & ~eff_mask_first)
        | |(state_reg.cause_second & ~eff_mask_second);

    assign status_value = {state_reg.stable.sync_too_fast_flag,
        state_reg.stable.sync_too_slow_flag, state_reg.stable.bias_full_duty,
        state_reg.stable.main_const_current, state_reg.stable.main_full_duty,
        state_reg.stable.main_power_good, 2'h0};

    assign cfg_wr = req_i.wr && (req_i.addr == buck_regs_pkg::CONFIG_FIRST_ADDR);

    always_comb begin
        case (state_reg.pg_sel)
            2'h0: pg_target = '0;
            2'h1: pg_target = CW'(PG_DLY1_CYC);
            2'h2: pg_target = CW'(PG_DLY2_CYC);
            default: pg_target = CW'(PG_DLY3_CYC);
        endcase
    end

    always_comb begin
        case (state_reg.bias_sel)
            2'h0: bias_target = CW'(BIAS_DLY0_CYC);
            2'h1: bias_target = CW'(BIAS_DLY1_CYC);
            2'h2: bias_target = CW'(BIAS_DLY2_CYC);
            default: bias_target = CW'(BIAS_DLY3_CYC);
        endcase
    end

    always_comb begin
        state_next = state_reg;

        // Three-stage synchroniser, change taken once stages two and three agree
        state_next.sync1 = analog_i;
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        if (state_reg.sync2 == state_reg.sync3) begin
            state_next.stable = state_reg.sync3;
        end

        state_next.apply_pulse = 1'b0;
        state_next.enable_pulse = 1'b0;
        if (req_i.wr && (req_i.addr == buck_regs_pkg::ACTION_TRIGGER_ADDR)) begin
            state_next.apply_pulse = req_i.wdata[buck_regs_pkg::APPLY_REF_BIT];
            state_next.enable_pulse = req_i.wdata[buck_regs_pkg::MAIN_ENABLE_BIT];
        end

        if (req_i.wr && (req_i.addr == buck_regs_pkg::IRQ_MASK_FIRST_ADDR)) begin
            state_next.mask_first = req_i.wdata & buck_regs_pkg::CAUSE_FIRST_USED;
        end
        if (req_i.wr && (req_i.addr == buck_regs_pkg::IRQ_MASK_SECOND_ADDR)) begin
            state_next.mask_second = req_i.wdata & buck_regs_pkg::CAUSE_SECOND_USED;
        end
        if (cfg_wr) begin
            state_next.pg_sel = req_i.wdata[buck_regs_pkg::POWER_GOOD_DELAY_SEL_LSB +: 2];
            state_next.mask_all = req_i.wdata[buck_regs_pkg::MASK_ALL_BIT];
            state_next.bias_sel = req_i.wdata[buck_regs_pkg::BIAS_DELAY_LSB +: 2];
        end

        // read clears resolved causes, a new event wins
        if (req_i.rd && (req_i.addr == buck_regs_pkg::CAUSE_FIRST_ADDR)) begin
            state_next.cause_first = state_reg.cause_first
                & state_reg.stable.cause_first;
        end
        if (req_i.rd && (req_i.addr == buck_regs_pkg::CAUSE_SECOND_ADDR)) begin
            state_next.cause_second = state_reg.cause_second
                & state_reg.stable.cause_second;
        end
        state_next.cause_first = state_next.cause_first
            | (state_reg.stable.cause_first & buck_regs_pkg::CAUSE_FIRST_USED);
        state_next.cause_second = state_next.cause_second
            | (state_reg.stable.cause_second & buck_regs_pkg::CAUSE_SECOND_USED);

        // Read data, held until the next read
        if (req_i.rd) begin
            if (req_i.addr == buck_regs_pkg::CAUSE_FIRST_ADDR) begin
                state_next.rdata = state_reg.cause_first;
            end else if (req_i.addr == buck_regs_pkg::CAUSE_SECOND_ADDR) begin
                state_next.rdata = state_reg.cause_second;
            end else if (req_i.addr == buck_regs_pkg::STATUS_FLAGS_ADDR) begin
                state_next.rdata = status_value;
            end else if (req_i.addr == buck_regs_pkg::IRQ_MASK_FIRST_ADDR) begin
                state_next.rdata = state_reg.mask_first;
            end else if (req_i.addr == buck_regs_pkg::IRQ_MASK_SECOND_ADDR) begin
                state_next.rdata = state_reg.mask_second;
            end else if (req_i.addr == buck_regs_pkg::CONFIG_FIRST_ADDR) begin
                state_next.rdata = {state_reg.pg_sel, state_reg.mask_all,
                    state_reg.bias_sel, 3'h0};
            end else begin
                // reserved slot and command read zero
                state_next.rdata = 8'h00;
            end
        end

        // power-good pin follows condition after delay
        if (!state_reg.stable.main_power_good) begin
            state_next.pg_cnt = '0;
            state_next.pg_pin = 1'b0;
        end else if (state_reg.pg_cnt >= pg_target) begin
            state_next.pg_pin = 1'b1;
        end else begin
            state_next.pg_cnt = state_reg.pg_cnt + CW'(1);
        end

        // bias-good pin follows condition after delay
        if (!state_reg.stable.bias_power_good) begin
            state_next.bias_cnt = '0;
            state_next.bias_pin = 1'b0;
        end else if (state_reg.bias_cnt >= bias_target) begin
            state_next.bias_pin = 1'b1;
        end else begin
            state_next.bias_cnt = state_reg.bias_cnt + CW'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= '0;
            state_reg.mask_first <= buck_regs_pkg::IRQ_MASK_RESET;
            state_reg.mask_second <= buck_regs_pkg::IRQ_MASK_RESET;
            state_reg.pg_sel <= buck_regs_pkg::POWER_GOOD_DELAY_SEL_RESET;
            state_reg.mask_all <= buck_regs_pkg::MASK_ALL_RESET;
            state_reg.bias_sel <= buck_regs_pkg::BIAS_DELAY_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data_o = state_reg.rdata;
    assign apply_reference_cmd_o = state_reg.apply_pulse;
    assign main_enable_start_o = state_reg.enable_pulse;
    assign power_good_pin_o = state_reg.pg_pin;
    assign bias_good_pin_o = state_reg.bias_pin;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence cmd_write_s(int bitpos);
        req_i.wr && req_i.addr == buck_regs_pkg::ACTION_TRIGGER_ADDR
            && req_i.wdata[bitpos];
    endsequence

    sequence one_cycle_pulse_s(logic sig);
        sig ##1 !sig;
    endsequence

    chk_status_read: assert property (
        req_i.rd && req_i.addr == buck_regs_pkg::STATUS_FLAGS_ADDR
        |=> rd_data_o == {$past(state_reg.stable.sync_too_fast_flag),
            $past(state_reg.stable.sync_too_slow_flag),
            $past(state_reg.stable.bias_full_duty),
            $past(state_reg.stable.main_const_current),
            $past(state_reg.stable.main_full_duty),
            $past(state_reg.stable.main_power_good), 2'h0})
        else $error("status read value wrong");

    chk_reserved_zero: assert property (
        req_i.rd && req_i.addr == buck_regs_pkg::RESERVED_SLOT_ADDR |=> rd_data_o == 8'h00)
        else $error("reserved slot read not zero");

    chk_apply_ref_pulse: assert property (
        cmd_write_s(buck_regs_pkg::APPLY_REF_BIT) |=> one_cycle_pulse_s(apply_reference_cmd_o))
        else $error("apply reference pulse missing");

    chk_main_enable_pulse: assert property (
        cmd_write_s(buck_regs_pkg::MAIN_ENABLE_BIT) |=> one_cycle_pulse_s(main_enable_start_o))
        else $error("main enable pulse missing");

    chk_no_stray_cmd: assert property (
        !(req_i.wr && req_i.addr == buck_regs_pkg::ACTION_TRIGGER_ADDR)
        |=> !apply_reference_cmd_o && !main_enable_start_o)
        else $error("command pulse without write");

    chk_cmd_reads_zero: assert property (
        req_i.rd && req_i.addr == buck_regs_pkg::ACTION_TRIGGER_ADDR |=> rd_data_o == 8'h00)
        else $error("command register read not zero");

    chk_mask_all_quiet: assert property (
        state_reg.mask_all |-> !irq_o)
        else $error("interrupt despite mask-all");

    chk_mask_all_reset: assert property (@(posedge sys_clk_i) disable iff (1'b0)
        reset_i |=> state_reg.mask_all)
        else $error("mask-all not set by reset");

    chk_unused_mask_bits: assert property (
        (state_reg.mask_first & ~buck_regs_pkg::CAUSE_FIRST_USED) == 8'h00
        && (state_reg.mask_second & ~buck_regs_pkg::CAUSE_SECOND_USED) == 8'h00)
        else $error("unused mask bit set");

    chk_cause_held: assert property (
        !(req_i.rd && req_i.addr == buck_regs_pkg::CAUSE_FIRST_ADDR)
        |=> (state_reg.cause_first & $past(state_reg.cause_first))
            == $past(state_reg.cause_first))
        else $error("cause bit lost without read");

    chk_pg_drop: assert property (
        !state_reg.stable.main_power_good |=> !power_good_pin_o)
        else $error("power-good pin high without condition");

    chk_pg_no_delay: assert property (
        state_reg.pg_sel == 2'h0 && !cfg_wr && state_reg.stable.main_power_good
        ##1 state_reg.stable.main_power_good |-> power_good_pin_o)
        else $error("power-good pin late with zero delay");

    chk_bias_drop: assert property (
        !state_reg.stable.bias_power_good |=> !bias_good_pin_o)
        else $error("bias-good pin high without condition");

endmodule

// >>> host_model.sv
/* Host model for the register strobe port of the converter register slice.
   Assumes the bench calls its tasks from procedural code on one clock. */
`timescale 1ns/10ps
module host_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] rd_data_i,
    output buck_regs_pkg::reg_req_s req_o
);
    initial req_o = '0;

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk_i);
        #1;
        req_o = '0;
    endtask

    // Read data is taken one cycle after the read edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk_i);
        #1;
        req_o = '0;
        d = rd_data_i;
    endtask
endmodule

// >>> test_buck_status_mask_config_regs.sv
/* Self-checking bench for the converter status, mask and config registers.
   Assumes the host model and shortened good-pin delay parameters. */
`timescale 1ns/10ps
module test_buck_status_mask_config_regs;
    logic sys_clk = 1'b0;
    logic reset_i = 1'b1;
    buck_regs_pkg::analog_in_s ana = '0;
    buck_regs_pkg::reg_req_s req;
    logic [7:0] rd_data;
    logic irq, apply, men, pgp, bgp;
    logic [7:0] v;
    int err_count = 0;
    int compares = 0;
    int pgc [4];
    int bgc [4];
    // Shortened good-pin delays in cycles, so the delay sweeps stay short
    localparam int PG_D1 = 5;
    localparam int PG_D2 = 10;
    localparam int PG_D3 = 20;
    localparam int BS_D0 = 4;
    localparam int BS_D1 = 6;
    localparam int BS_D2 = 8;
    localparam int BS_D3 = 12;

    always #5 sys_clk = ~sys_clk;

    host_model host (.sys_clk_i(sys_clk), .rd_data_i(rd_data), .req_o(req));

    buck_status_mask_config_regs #(.PG_DLY1_CYC(PG_D1), .PG_DLY2_CYC(PG_D2),
        .PG_DLY3_CYC(PG_D3), .BIAS_DLY0_CYC(BS_D0), .BIAS_DLY1_CYC(BS_D1),
        .BIAS_DLY2_CYC(BS_D2), .BIAS_DLY3_CYC(BS_D3)) dut (
        .sys_clk_i(sys_clk), .reset_i(reset_i), .req_i(req), .analog_i(ana),
        .rd_data_o(rd_data), .irq_o(irq), .apply_reference_cmd_o(apply),
        .main_enable_start_o(men), .power_good_pin_o(pgp), .bias_good_pin_o(bgp));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, v);
        check(v, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Inputs change just after an edge, then pass the synchroniser
    task automatic drive_ana(input buck_regs_pkg::analog_in_s a);
        @(posedge sys_clk);
        #1;
        ana = a;
        idle(6);
    endtask

    // Counts cycles from condition high to pin high, then drops it
    task automatic pin_rise(input logic gb, output int cnt);
        @(posedge sys_clk);
        #1;
        ana.main_power_good = !gb;
        ana.bias_power_good = gb;
        cnt = 0;
        while ((gb ? bgp : pgp) !== 1'b1 && cnt < 200) begin
            idle(1);
            cnt++;
        end
        ana = '0;
        idle(8);
        check({7'h00, (gb ? bgp : pgp)}, 8'h00);
    endtask

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        #1;
        reset_i = 1'b0;
        rchk(8'h06, 8'h00);
        rchk(8'h07, 8'h00);
        rchk(8'h08, 8'h28);
        rchk(8'h03, 8'h00);
        rchk(8'h04, 8'h00);
        rchk(8'h05, 8'h00);
        rchk(8'h0F, 8'h00);
        $display("Test reset values done");
        host.write_reg(8'h06, 8'hFF);
        host.write_reg(8'h07, 8'hFF);
        host.write_reg(8'h04, 8'hFF);
        host.write_reg(8'h03, 8'hFF);
        host.write_reg(8'h08, 8'hFF);
        rchk(8'h06, 8'hBD);
        rchk(8'h07, 8'h7F);
        rchk(8'h04, 8'h00);
        rchk(8'h03, 8'h00);
        rchk(8'h08, 8'hF8);
        $display("Test writable bits done");
        for (int i = 0; i < 6; i++) begin
            drive_ana(buck_regs_pkg::analog_in_s'(23'h1 << (22 - i)));
            rchk(8'h03, 8'h80 >> i);
        end
        drive_ana('0);
        $display("Test status flags done");
        host.write_reg(8'h05, 8'h02);
        check({6'h00, apply, men}, 8'h02);
        idle(1);
        check({6'h00, apply, men}, 8'h00);
        host.write_reg(8'h05, 8'h01);
        check({6'h00, apply, men}, 8'h01);
        host.write_reg(8'h05, 8'h03);
        check({6'h00, apply, men}, 8'h03);
        rchk(8'h05, 8'h00);
        $display("Test command done");
        host.write_reg(8'h06, 8'h00);
        host.write_reg(8'h07, 8'h00);
        host.write_reg(8'h08, 8'h28);
        drive_ana(buck_regs_pkg::analog_in_s'(23'h000100));
        check({7'h00, irq}, 8'h00);
        host.write_reg(8'h08, 8'h08);
        check({7'h00, irq}, 8'h01);
        host.write_reg(8'h06, 8'h01);
        check({7'h00, irq}, 8'h00);
        drive_ana(buck_regs_pkg::analog_in_s'(23'h000120));
        check({7'h00, irq}, 8'h01);
        host.write_reg(8'h07, 8'h20);
        check({7'h00, irq}, 8'h00);
        rchk(8'h01, 8'h01);
        rchk(8'h01, 8'h01);
        drive_ana('0);
        rchk(8'h01, 8'h01);
        rchk(8'h01, 8'h00);
        rchk(8'h02, 8'h20);
        rchk(8'h02, 8'h00);
        $display("Test interrupt masking done");
        for (int s = 0; s < 4; s++) begin
            host.write_reg(8'h08, 8'((s << 6) | 8'h28));
            pin_rise(1'b0, pgc[s]);
            host.write_reg(8'h08, 8'((s << 3) | 8'h20));
            pin_rise(1'b1, bgc[s]);
        end
        check(8'(pgc[1] - pgc[0]), 8'(PG_D1));
        check(8'(pgc[2] - pgc[1]), 8'(PG_D2 - PG_D1));
        check(8'(pgc[3] - pgc[1]), 8'(PG_D3 - PG_D1));
        check(8'(bgc[1] - bgc[0]), 8'(BS_D1 - BS_D0));
        check(8'(bgc[2] - bgc[0]), 8'(BS_D2 - BS_D0));
        check(8'(bgc[3] - bgc[0]), 8'(BS_D3 - BS_D0));
        $display("Test good-pin delays done");
        give_verdict();
    end
endmodule
